//--- design/hif_regs.sv
`timescale 1ns/1ns
module hif_regs
	import hif_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] irq_status_reg,
	output logic host_irq,
	input wire logic [LEVEL_W-1:0] tx_data_free,
	input wire logic [LEVEL_W-1:0] tx_stat_used,
	input wire logic [LEVEL_W-1:0] rx_data_free,
	input wire logic [LEVEL_W-1:0] rx_stat_used,
	output logic tx_space_avail_event,
	output logic tx_stat_level_event,
	output logic rx_data_level_event,
	output logic rx_stat_level_event,
	input wire logic rx_word_taken,
	input wire logic rx_last_word,
	output logic rx_pad_active,
	output logic wake_pulse
);
	logic [31:0] mask_q;
	logic [31:0] thr_q;
	logic [31:0] rxcfg_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	hif_sel_t rd_sel_q;
	logic wake_q;
	logic wr_go;
	logic rd_go;
	hif_sel_t wr_sel;
	hif_sel_t rd_sel;
	logic [LEVEL_W-1:0] lvl [4];
	logic [7:0] thr_fld [4];
	logic lvl_below [4];
	logic lvl_evt [4];

	////////////////////////////////////////////////////////////////////
	// address decode and byte-lane merge

	function automatic hif_sel_t decode(input logic [7:0] a);
		case (a[7:2])
			OFS_IRQ_MASK[7:2]: decode = SEL_MASK;
			OFS_BYTE_PROBE[7:2]: decode = SEL_PROBE;
			OFS_FIFO_THR[7:2]: decode = SEL_THR;
			OFS_RX_CFG[7:2]: decode = SEL_RXCFG;
			default: decode = SEL_NONE;
		endcase
	endfunction

	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0] strb,
		input logic [31:0] rw
	);
		logic [31:0] be;
		be = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & rw;
		merge = (old & ~be) | (wd & be);
	endfunction

	assign wr_sel = decode(s_axi_awaddr);
	assign rd_sel = decode(s_axi_araddr);

	////////////////////////////////////////////////////////////////////
	// write channel: address and data taken together, response next cycle

	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	assign s_axi_wready = s_axi_awready;
	assign wr_go = s_axi_awready;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// mask register, reserved bits held zero
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			mask_q <= IRQ_MASK_RESET;
		end else if (wr_go && wr_sel == SEL_MASK) begin
			mask_q <= merge(mask_q, s_axi_wdata, s_axi_wstrb, IRQ_MASK_RW);
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			thr_q <= FIFO_THR_RESET;
		end else if (wr_go && wr_sel == SEL_THR) begin
			thr_q <= merge(thr_q, s_axi_wdata, s_axi_wstrb, 32'hffff_ffff);
		end
	end

	// only the alignment field is kept
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rxcfg_q <= RX_CFG_RESET;
		end else if (wr_go && wr_sel == SEL_RXCFG) begin
			rxcfg_q <= merge(rxcfg_q, s_axi_wdata, s_axi_wstrb, RX_CFG_RW);
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= wr_go && (wr_sel == SEL_PROBE);
		end
	end
	assign wake_pulse = wake_q;

	////////////////////////////////////////////////////////////////////
	// read channel: data one cycle after the address is taken

	assign s_axi_arready = !rvalid_q;
	assign rd_go = s_axi_arvalid && !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0000_0000;
			rd_sel_q <= SEL_NONE;
		end else if (rd_go) begin
			rvalid_q <= 1'b1;
			rd_sel_q <= rd_sel;
			rresp_q <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			case (rd_sel)
				SEL_MASK: rdata_q <= mask_q;
				SEL_PROBE: rdata_q <= BYTE_ORDER_VALUE;
				SEL_THR: rdata_q <= thr_q;
				SEL_RXCFG: rdata_q <= rxcfg_q;
				default: rdata_q <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupt gating; flags stay visible to the status block unmasked

	assign host_irq = |(irq_status_reg & mask_q);

	////////////////////////////////////////////////////////////////////
	// fifo level comparators

	assign lvl[0] = tx_data_free;
	assign lvl[1] = tx_stat_used;
	assign lvl[2] = rx_data_free;
	assign lvl[3] = rx_stat_used;
	assign thr_fld[0] = thr_q[TX_SPACE_LSB +: 8];
	assign thr_fld[1] = thr_q[TX_STAT_LSB +: 8];
	assign thr_fld[2] = thr_q[RX_DATA_LSB +: 8];
	assign thr_fld[3] = thr_q[RX_STAT_LSB +: 8];
	assign lvl_below[0] = 1'b0;
	assign lvl_below[1] = 1'b0;
	assign lvl_below[2] = 1'b1;
	assign lvl_below[3] = 1'b0;

	for (genvar i = 0; i < 4; i++) begin : g_lvl
		hif_level_cmp u_cmp (
			.ref_clk(ref_clk),
			.reset_n(reset_n),
			.level(lvl[i]),
			.threshold(thr_fld[i]),
			.below(lvl_below[i]),
			.event_q(lvl_evt[i])
		);
	end

	assign tx_space_avail_event = lvl_evt[0];
	assign tx_stat_level_event = lvl_evt[1];
	assign rx_data_level_event = lvl_evt[2];
	assign rx_stat_level_event = lvl_evt[3];

	////////////////////////////////////////////////////////////////////
	// receive end alignment

	hif_align_pad u_pad (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.align_code(rxcfg_q[ALIGN_LSB +: 2]),
		.word_taken(rx_word_taken),
		.last_word(rx_last_word),
		.pad_active(rx_pad_active)
	);

	////////////////////////////////////////////////////////////////////
	// checks

	property p_irq_on;
		@(posedge ref_clk) disable iff (!reset_n)
		(irq_status_reg[SOFT_IRQ_BIT] && mask_q[SOFT_IRQ_BIT]) |-> host_irq;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("enabled flag missed");

	property p_irq_off;
		@(posedge ref_clk) disable iff (!reset_n)
		(mask_q == 32'h0000_0000) |-> !host_irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("masked flag leaked");

	property p_mask_rsvd;
		@(posedge ref_clk) disable iff (!reset_n)
		(mask_q & ~IRQ_MASK_RW) == 32'h0000_0000;
	endproperty
	a_mask_rsvd: assert property (p_mask_rsvd) else $error("mask reserved set");

	property p_mask_wr;
		@(posedge ref_clk) disable iff (!reset_n)
		(wr_go && wr_sel == SEL_MASK && s_axi_wstrb[3])
		|=> mask_q[SOFT_IRQ_BIT] == $past(s_axi_wdata[SOFT_IRQ_BIT]);
	endproperty
	a_mask_wr: assert property (p_mask_wr) else $error("soft enable not written");

	property p_probe;
		@(posedge ref_clk) disable iff (!reset_n)
		(s_axi_rvalid && rd_sel_q == SEL_PROBE) |-> s_axi_rdata == BYTE_ORDER_VALUE;
	endproperty
	a_probe: assert property (p_probe) else $error("probe value wrong");

	property p_tx_space;
		@(posedge ref_clk) disable iff (!reset_n)
		(tx_data_free > {1'b0, thr_q[TX_SPACE_LSB +: 8]}) |=> tx_space_avail_event;
	endproperty
	a_tx_space: assert property (p_tx_space) else $error("tx space event missed");

	property p_rx_data;
		@(posedge ref_clk) disable iff (!reset_n)
		(rx_data_free >= {1'b0, thr_q[RX_DATA_LSB +: 8]}) |=> !rx_data_level_event;
	endproperty
	a_rx_data: assert property (p_rx_data) else $error("rx data event false");

	property p_wake;
		@(posedge ref_clk) disable iff (!reset_n)
		wake_pulse |-> $past(wr_go) && $past(wr_sel) == SEL_PROBE;
	endproperty
	a_wake: assert property (p_wake) else $error("wake without probe write");

	property p_rxcfg_rsvd;
		@(posedge ref_clk) disable iff (!reset_n)
		(rxcfg_q & ~RX_CFG_RW) == 32'h0000_0000;
	endproperty
	a_rxcfg_rsvd: assert property (p_rxcfg_rsvd) else $error("rx cfg reserved set");

	property p_bresp;
		@(posedge ref_clk) disable iff (!reset_n)
		wr_go |=> s_axi_bvalid;
	endproperty
	a_bresp: assert property (p_bresp) else $error("write response lost");

	c_irq: cover property (@(posedge ref_clk) disable iff (!reset_n) host_irq);
	c_wake: cover property (@(posedge ref_clk) disable iff (!reset_n) wake_pulse);
	c_probe: cover property (@(posedge ref_clk) disable iff (!reset_n)
		s_axi_rvalid && rd_sel_q == SEL_PROBE);
endmodule

//--- include/hif_pkg.sv
// Summary of operation
// - a set mask bit lets its event source drive the host interrupt line
// - status flags keep reporting their source whatever the mask holds
// - mask bit 31 is the read/write software interrupt enable, reset zero
// - mask bits 25, 24, 23 enable tx halted, rx halted, drop count half
// - mask bits 21 to 16 enable buffer done, dma, timer, phy, power, overflow
// - mask bits 15, 14, 13 enable oversize, receive error, transmit error
// - mask bits 11 to 7 enable the five transmit fifo events
// - mask bits 6 to 3 enable receive events, bits 2 to 0 pin events
// - byte order probe is read-only and always returns 87654321h
// - tx space event when free 64-byte blocks exceed bits 31-24, reset 48h
// - tx status level event when used words exceed bits 23-16, reset zero
// - rx data level event when free 64-byte blocks fall below bits 15-8
// - rx status level event when used words exceed bits 7-0, reset zero
// - pad last transfer of each receive buffer to the chosen boundary
// - alignment code 00 is 4 bytes, 01 is 16, 10 is 32, 11 reserved
// - after a power event wake only on a host write to the probe
package hif_pkg;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h5c;
	localparam logic [7:0] OFS_BYTE_PROBE = 8'h64;
	localparam logic [7:0] OFS_FIFO_THR = 8'h68;
	localparam logic [7:0] OFS_RX_CFG = 8'h6c;
	localparam logic [31:0] BYTE_ORDER_VALUE = 32'h8765_4321;
	localparam logic [31:0] IRQ_MASK_RESET = 32'h0000_0000;
	localparam logic [31:0] IRQ_MASK_RW = 32'h83bf_efff;
	localparam logic [31:0] FIFO_THR_RESET = 32'h4800_0000;
	localparam logic [31:0] RX_CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] RX_CFG_RW = 32'hc000_0000;
	localparam int SOFT_IRQ_BIT = 31;
	localparam int POWER_EVENT_BIT = 17;
	localparam int TX_SPACE_LSB = 24;
	localparam int TX_STAT_LSB = 16;
	localparam int RX_DATA_LSB = 8;
	localparam int RX_STAT_LSB = 0;
	localparam int ALIGN_LSB = 30;
	localparam int LEVEL_W = 9;
	localparam logic [1:0] ALIGN_4B = 2'b00;
	localparam logic [1:0] ALIGN_16B = 2'b01;
	localparam logic [1:0] ALIGN_32B = 2'b10;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [2:0] {
		SEL_NONE = 3'h0,
		SEL_MASK = 3'h1,
		SEL_PROBE = 3'h2,
		SEL_THR = 3'h3,
		SEL_RXCFG = 3'h4
	} hif_sel_t;
	typedef enum logic [1:0] {
		AL_IDLE = 2'b00,
		AL_DATA = 2'b01,
		AL_PAD = 2'b11
	} hif_align_st_t;
endpackage

//--- design/hif_level_cmp.sv
`timescale 1ns/1ns
module hif_level_cmp
	import hif_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [LEVEL_W-1:0] level,
	input wire logic [7:0] threshold,
	input wire logic below,
	output logic event_q
);
	logic [LEVEL_W-1:0] thr_ext;
	assign thr_ext = {{(LEVEL_W-8){1'b0}}, threshold};

	// above mode fires on level > threshold, below mode on level < threshold
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			event_q <= 1'b0;
		end else if (below) begin
			event_q <= (level < thr_ext);
		end else begin
			event_q <= (level > thr_ext);
		end
	end
endmodule

//--- design/hif_align_pad.sv
`timescale 1ns/1ns
module hif_align_pad
	import hif_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [1:0] align_code,
	input wire logic word_taken,
	input wire logic last_word,
	output logic pad_active
);
	hif_align_st_t state_q, state_d;
	logic [2:0] pos_q, pos_d;
	logic [2:0] wmask_q, wmask_d;
	logic [2:0] pos_n;
	logic aligned_n;

	// boundary in words, less one
	function automatic logic [2:0] words_mask(input logic [1:0] code);
		case (code)
			ALIGN_4B: words_mask = 3'h0;
			ALIGN_16B: words_mask = 3'h3;
			ALIGN_32B: words_mask = 3'h7;
			default: words_mask = 3'h0;
		endcase
	endfunction

	assign wmask_d = (state_q == AL_IDLE) ? words_mask(align_code) : wmask_q;
	assign pos_n = ((state_q == AL_IDLE) ? 3'h0 : pos_q) + 3'h1;
	assign aligned_n = ((pos_n & wmask_d) == 3'h0);
	assign pad_active = (state_q == AL_PAD);

	always_comb begin
		state_d = state_q;
		pos_d = pos_q;
		if (word_taken) begin
			pos_d = pos_n;
			case (state_q)
				AL_IDLE, AL_DATA: begin
					if (last_word) begin
						state_d = aligned_n ? AL_IDLE : AL_PAD;
					end else begin
						state_d = AL_DATA;
					end
				end
				AL_PAD: begin
					state_d = aligned_n ? AL_IDLE : AL_PAD;
				end
				default: state_d = AL_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= AL_IDLE;
			pos_q <= 3'h0;
			wmask_q <= 3'h0;
		end else begin
			state_q <= state_d;
			pos_q <= pos_d;
			wmask_q <= wmask_d;
		end
	end

	property p_pad_start;
		@(posedge ref_clk) disable iff (!reset_n)
		(word_taken && last_word && state_q != AL_PAD && !aligned_n) |=> pad_active;
	endproperty
	a_pad_start: assert property (p_pad_start) else $error("pad not started");

	// 32-byte pads at most 7 words
	property p_pad_ends;
		@(posedge ref_clk) disable iff (!reset_n)
		(pad_active && word_taken && aligned_n) |=> !pad_active;
	endproperty
	a_pad_ends: assert property (p_pad_ends) else $error("pad overran boundary");

	c_pad: cover property (@(posedge ref_clk) disable iff (!reset_n) pad_active);
endmodule

//--- tb/hif_host_model.sv
`timescale 1ns/1ns
module hif_host_model (
	input wire logic ref_clk,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		logic a_ok;
		logic w_ok;
		a_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(a_ok && w_ok)) begin
			@(posedge ref_clk);
			if (awready === 1'b1)
				a_ok = 1'b1;
			if (wready === 1'b1)
				w_ok = 1'b1;
			if (a_ok)
				awvalid <= 1'b0;
			if (w_ok)
				wvalid <= 1'b0;
		end
		// released lines stop showing the old value
		awaddr <= ~a;
		wdata <= ~d;
		do @(posedge ref_clk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge ref_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		araddr <= ~a;
		do @(posedge ref_clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule

//--- tb/tb_hif_regs.sv
`timescale 1ns/1ns
module tb_hif_regs;
	import hif_pkg::*;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] irq_status_reg = 32'h0;
	logic [LEVEL_W-1:0] tx_data_free = '0, tx_stat_used = '0, rx_data_free = '0, rx_stat_used = '0;
	logic rx_word_taken = 1'b0, rx_last_word = 1'b0;
	logic host_irq, tx_space_avail_event, tx_stat_level_event, rx_data_level_event;
	logic rx_stat_level_event, rx_pad_active, wake_pulse;
	logic [31:0] rnd = 32'h319d58fc;
	logic [31:0] d;
	logic [31:0] mdl [3];
	logic [7:0] ofs [3] = '{OFS_IRQ_MASK, OFS_FIFO_THR, OFS_RX_CFG};
	logic [31:0] rwm [3] = '{IRQ_MASK_RW, 32'hffff_ffff, RX_CFG_RW};
	int bad_count = 0, n_tests = 0, cyc = 0, wakes = 0;
	int lv [4];
	int blk, cnt, n;

	hif_regs dut (.ref_clk(ref_clk), .reset_n(reset_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.irq_status_reg(irq_status_reg), .host_irq(host_irq),
		.tx_data_free(tx_data_free), .tx_stat_used(tx_stat_used),
		.rx_data_free(rx_data_free), .rx_stat_used(rx_stat_used),
		.tx_space_avail_event(tx_space_avail_event), .tx_stat_level_event(tx_stat_level_event),
		.rx_data_level_event(rx_data_level_event), .rx_stat_level_event(rx_stat_level_event),
		.rx_word_taken(rx_word_taken), .rx_last_word(rx_last_word),
		.rx_pad_active(rx_pad_active), .wake_pulse(wake_pulse));
	hif_host_model host (.ref_clk(ref_clk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (wake_pulse === 1'b1)
			wakes <= wakes + 1;
		if (cyc == 20000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] nxt(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] o, w, input logic [3:0] s,
		input logic [31:0] m);
		for (int b = 0; b < 4; b++)
			if (s[b])
				o[8*b+:8] = w[8*b+:8];
		return o & m;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (bad_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		mdl = '{32'h0, 32'h4800_0000, 32'h0};
		repeat (16) @(posedge ref_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			host.rd(ofs[i], d, r);
			chk(d, mdl[i]);
		end
		for (int k = 0; k < 24; k++) begin
			rnd = nxt(rnd);
			d = rnd;
			rnd = nxt(rnd);
			host.wr(ofs[k % 3], d, rnd[3:0], r);
			mdl[k % 3] = merge(mdl[k % 3], d, rnd[3:0], rwm[k % 3]);
			host.rd(ofs[k % 3], d, r);
			chk(d, mdl[k % 3]);
			chk({30'h0, r}, 32'h0);
		end
		n = wakes;
		host.wr(OFS_BYTE_PROBE, rnd, 4'hf, r);
		chk({30'h0, r}, 32'h0);
		host.wr(8'h60, rnd, 4'hf, r);
		chk({30'h0, r}, 32'h2);
		host.rd(8'h60, d, r);
		chk(d, 32'h0);
		chk({30'h0, r}, 32'h2);
		host.rd(OFS_BYTE_PROBE, d, r);
		chk(d, 32'h8765_4321);
		chk({30'h0, r}, 32'h0);
		chk(32'(wakes - n), 32'h1);
		for (int i = 0; i < 32; i++) begin
			host.wr(OFS_IRQ_MASK, 32'h1 << i, 4'hf, r);
			@(posedge ref_clk);
			irq_status_reg <= ~(32'h1 << i);
			#1;
			chk({31'h0, host_irq}, 32'h0);
			@(posedge ref_clk);
			irq_status_reg <= 32'h1 << i;
			#1;
			chk({31'h0, host_irq}, {31'h0, IRQ_MASK_RW[i]});
		end
		for (int k = 0; k < 12; k++) begin
			rnd = nxt(rnd);
			d = rnd;
			host.wr(OFS_FIFO_THR, d, 4'hf, r);
			for (int j = 0; j < 4; j++)
				lv[j] = (int'(d[8*j+:8]) + k % 3 - 1) & 32'h1ff;
			rx_stat_used <= 9'(lv[0]);
			rx_data_free <= 9'(lv[1]);
			tx_stat_used <= 9'(lv[2]);
			tx_data_free <= 9'(lv[3]);
			@(posedge ref_clk);
			#1;
			chk({31'h0, tx_space_avail_event}, 32'(lv[3] > d[31:24]));
			chk({31'h0, tx_stat_level_event}, 32'(lv[2] > d[23:16]));
			chk({31'h0, rx_data_level_event}, 32'(lv[1] < d[15:8]));
			chk({31'h0, rx_stat_level_event}, 32'(lv[0] > d[7:0]));
		end
		for (int k = 0; k < 12; k++) begin
			rnd = nxt(rnd);
			n = int'(rnd[3:0]) % 9 + 1;
			blk = (k % 4 == 1) ? 4 : ((k % 4 == 2) ? 8 : 1);
			host.wr(OFS_RX_CFG, {2'(k), 30'h0}, 4'h8, r);
			for (int w = 1; w <= n; w++) begin
				rx_word_taken <= 1'b1;
				rx_last_word <= (w == n);
				@(posedge ref_clk);
			end
			rx_word_taken <= 1'b0;
			rx_last_word <= 1'b0;
			#1;
			cnt = 0;
			while (rx_pad_active === 1'b1 && cnt < 9) begin
				@(posedge ref_clk);
				rx_word_taken <= 1'b1;
				@(posedge ref_clk);
				rx_word_taken <= 1'b0;
				#1;
				cnt++;
			end
			chk(32'(cnt), 32'((blk - n % blk) % blk));
		end
		tally_and_finish();
	end
endmodule
